// >>> stack_limit_checker.sv
// checker for the stack unit: pointer steps, trap causes, address bits.
// assumes it is bound onto system_stack_limit_unit.
`timescale 1ns/100ps
`default_nettype none
module stack_limit_checker (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire stack_unit_pkg::stack_cmd_t cmd,
  input wire logic [15:0]               stack_pointer,
  input wire stack_unit_pkg::mem_req_t  mem_req,
  input wire logic                      overflow_trap,
  input wire logic                      underflow_trap,
  input wire stack_unit_pkg::ustk_req_t ustk_req,
  input wire stack_unit_pkg::ustk_rsp_t ustk_rsp
);
  import stack_unit_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pointer steps stay inside the 4k window
  function automatic logic [15:0] win(input logic [15:0] v);
    return (v & 16'h0ffe) | 16'hf000;
  endfunction
  sequence push_s; cmd.op inside {OP_PUSH, OP_CALL}; endsequence
  sequence pop_s; cmd.op inside {OP_POP, OP_RET}; endsequence
  push_dec_a: assert property (push_s |=>
    stack_pointer == win($past(stack_pointer) - 16'h0002)) else $error("push step wrong");
  pop_inc_a: assert property (pop_s |=>
    stack_pointer == win($past(stack_pointer) + 16'h0002)) else $error("pop step wrong");
  sp_form_a: assert property (
    !stack_pointer[0] && stack_pointer[15:12] == 4'hf) else $error("pointer out of form");
  ovf_cause_a: assert property (overflow_trap |->
    $past(cmd.op) inside {OP_PUSH, OP_CALL, OP_SUB}) else $error("overflow without cause");
  unf_cause_a: assert property (underflow_trap |->
    $past(cmd.op) inside {OP_POP, OP_RET, OP_ADD}) else $error("underflow without cause");
  mov_quiet_a: assert property (cmd.op == OP_MOV |=> !overflow_trap && !underflow_trap
    && stack_pointer == win($past(cmd.operand))) else $error("move load wrong");
  idle_quiet_a: assert property (cmd.op == OP_NONE |=>
    !overflow_trap && !underflow_trap && !mem_req.valid) else $error("action while idle");
  push_addr_a: assert property (push_s |=> mem_req.valid && mem_req.write
    && mem_req.addr[5:0] == stack_pointer[5:0]) else $error("push address wrong");
  pop_addr_a: assert property (pop_s |=> mem_req.valid && !mem_req.write
    && mem_req.addr[5:0] == $past(stack_pointer[5:0])) else $error("pop address wrong");
  predec_a: assert property (ustk_req.mode == USTK_PREDEC && ustk_req.is_mov
    && !ustk_req.is_byte |=> ustk_rsp.valid && !ustk_rsp.refused
    && ustk_rsp.new_ptr == $past(ustk_req.ptr) - 16'h0002) else $error("predecrement wrong");
  postinc_a: assert property (ustk_req.mode == USTK_POSTINC && !ustk_req.is_mov
    && ustk_req.reg_index > 4'h3 |=> ustk_rsp.refused) else $error("postincrement taken");
endmodule
bind system_stack_limit_unit stack_limit_checker chk (.pclk, .presetn, .cmd, .stack_pointer,
  .mem_req, .overflow_trap, .underflow_trap, .ustk_req, .ustk_rsp);
`default_nettype wire

// >>> stack_ram_model.sv
// internal ram stand-in: keeps the last stack access it was sent.
// assumes mem_req pulses for one pclk cycle per access.
`timescale 1ns/100ps
`default_nettype none
module stack_ram_model (
  input  wire logic                     pclk,
  input  wire stack_unit_pkg::mem_req_t mem_req,
  output logic      [15:0]              last_addr,
  output logic                          last_write
);
  import stack_unit_pkg::*;
  // data is not stored: nothing is ever read back into the unit
  always_ff @(posedge pclk) begin
    if (mem_req.valid) begin
      last_addr  <= mem_req.addr;
      last_write <= mem_req.write;
    end
  end
endmodule
`default_nettype wire

// >>> stack_unit_pkg.sv
// package for the system stack limit unit: offsets, reset values,
// address masks, status bit positions and the carrier types.
// assumes a 100 MHz pclk domain and an APB register port.
package stack_unit_pkg;

  // register byte offsets on the APB port
  localparam logic [7:0] OFS_STACK_POINTER = 8'h00;
  localparam logic [7:0] OFS_OVERFLOW_LIM  = 8'h04;
  localparam logic [7:0] OFS_UNDERFLOW_LIM = 8'h08;
  localparam logic [7:0] OFS_SYSTEM_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK      = 8'h14;

  // reset values
  localparam logic [15:0] SP_RESET   = 16'hfc00;
  localparam logic [15:0] OVL_RESET  = 16'hfa00;
  localparam logic [15:0] UNL_RESET  = 16'hfc00;
  localparam logic [2:0]  SIZE_RESET = 3'b000;
  localparam logic [4:0]  MASK_RESET = 5'h00;

  // virtual window and physical area
  localparam logic [3:0]  WINDOW_PAGE = 4'hf;
  localparam logic [15:0] PHYS_TOP    = 16'hfbfe;
  localparam logic [15:0] LINEAR_LOW  = 16'hf600;
  localparam logic [15:0] LINEAR_HIGH = 16'hfdfe;
  localparam logic [15:0] WORD_STEP   = 16'h0002;
  localparam logic [15:0] BYTE_STEP   = 16'h0001;

  // size field codes and the pointer bits each one keeps
  localparam logic [2:0]  SIZE_256    = 3'b000;
  localparam logic [2:0]  SIZE_128    = 3'b001;
  localparam logic [2:0]  SIZE_64     = 3'b010;
  localparam logic [2:0]  SIZE_32     = 3'b011;
  localparam logic [2:0]  SIZE_LINEAR = 3'b111;
  localparam logic [15:0] MASK_256    = 16'h01ff;
  localparam logic [15:0] MASK_128    = 16'h00ff;
  localparam logic [15:0] MASK_64     = 16'h007f;
  localparam logic [15:0] MASK_32     = 16'h003f;

  // highest general register usable as post-increment pointer by non-move instructions
  localparam logic [3:0]  POSTINC_MAX_REG = 4'h3;

  // status and mask bit positions
  localparam int STAT_OVF     = 0;
  localparam int STAT_UNF     = 1;
  localparam int STAT_LINEAR  = 2;
  localparam int STAT_RSVSIZE = 3;
  localparam int STAT_USTK    = 4;
  localparam int STAT_W       = 5;

  typedef enum logic [2:0] {
    OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_SUB, OP_ADD, OP_MOV
  } stack_op_t;

  typedef struct packed {
    stack_op_t   op;
    logic [15:0] operand;
  } stack_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
  } mem_req_t;

  typedef enum logic [1:0] {USTK_NONE, USTK_PREDEC, USTK_POSTINC} ustk_mode_t;

  typedef struct packed {
    ustk_mode_t  mode;
    logic        is_mov;
    logic        is_byte;
    logic [3:0]  reg_index;
    logic [15:0] ptr;
  } ustk_req_t;

  typedef struct packed {
    logic        valid;
    logic        refused;
    logic [15:0] new_ptr;
    logic [15:0] addr;
  } ustk_rsp_t;

endpackage

// >>> system_stack_limit_unit.sv
// system stack pointer unit: pointer update, limit traps, physical
// address mapping, user stack pointer modes and an APB register port.
// assumes the core issues at most one stack command per pclk cycle.
//
// Summary of operation
// RULE1: pushes decrement the stack pointer by a word, pops increment it.
// RULE2: stack holds words only; pointer bit zero always reads zero.
// RULE3: call, push or subtract lowering pointer below overflow limit raises overflow trap.
// RULE4: return, pop or add raising pointer above underflow limit raises underflow trap.
// RULE5: a plain move into the pointer never triggers any limit check.
// RULE6: pointer and both limits live in the F000h to FFFEh window.
// RULE7: physical address joins low pointer bits with upper bits of FBFEh.
// RULE8: size codes 000..011 select 256, 128, 64 or 32 word stacks.
// RULE9: software must not program reserved size codes 100, 101, 110.
// RULE10: size 111 gives linear 1024 words, usable range F600h to FDFEh.
// RULE11: reset: overflow FA00h, underflow and pointer FC00h, size 000.
// RULE12: circular sizes wrap physical addresses while pointer keeps counting.
// RULE13: wrap only for 32 to 256 words; linear size never wraps.
// RULE14: software keeps linear stack out of F000h-F5FEh and the top registers.
// RULE15: software sets overflow limit six words beyond the internal area.
// RULE16: user stacks on general registers get no limit checking.
// RULE17: pre-decrement pushes byte or word, move only, any general register.
// RULE18: post-increment index mode pops, most instructions, only R0 to R3.
// RULE19: limits compared against updated pointer; one trap per offending command.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module system_stack_limit_unit (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire stack_unit_pkg::stack_cmd_t cmd,
  output logic      [15:0]                stack_pointer,
  output stack_unit_pkg::mem_req_t        mem_req,
  output logic                            overflow_trap,
  output logic                            underflow_trap,
  input  wire stack_unit_pkg::ustk_req_t  ustk_req,
  output stack_unit_pkg::ustk_rsp_t       ustk_rsp,
  output logic                            irq
);
  import stack_unit_pkg::*;

  // force a value into the word-aligned virtual window
  function automatic logic [15:0] fit_window(input logic [15:0] v);
    fit_window = {WINDOW_PAGE, v[11:1], 1'b0}; // RULE2 RULE6
  endfunction

  // physical address from pointer and size code
  function automatic logic [15:0] phys_addr(input logic [15:0] sp, input logic [2:0] sz);
    logic [15:0] m;
    m = MASK_256;
    case (sz)
      SIZE_256: m = MASK_256; // RULE8
      SIZE_128: m = MASK_128;
      SIZE_64:  m = MASK_64;
      SIZE_32:  m = MASK_32;
      default:  m = MASK_256;
    endcase
    // all modifiable bits in linear mode, so nothing wraps
    if (sz == SIZE_LINEAR) begin
      phys_addr = fit_window(sp); // RULE10 RULE13
    end else begin
      phys_addr = (PHYS_TOP & ~m) | (sp & m); // RULE7 RULE12
    end
  endfunction

  // ---------------- register state ----------------
  logic [15:0]        sp_q, sp_d;
  logic [15:0]        ovl_q, ovl_d;
  logic [15:0]        unl_q, unl_d;
  logic [2:0]         size_q, size_d;
  logic [STAT_W-1:0]  status_q, status_d;
  logic [STAT_W-1:0]  mask_q, mask_d;
  logic [31:0]        prdata_q, prdata_d;
  logic               pslverr_q, pslverr_d;
  mem_req_t           mem_q, mem_d;
  logic               ovf_q, ovf_d;
  logic               unf_q, unf_d;
  ustk_rsp_t          ustk_q, ustk_d;

  // apb decode
  logic        setup_ph;
  logic        wr_en;
  logic        mapped;
  logic [15:0] wdata16;
  logic [STAT_W-1:0] events;

  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign wdata16  = pwdata[15:0];

  // register offsets this slave answers
  always_comb begin
    case (paddr)
      OFS_STACK_POINTER, OFS_OVERFLOW_LIM, OFS_UNDERFLOW_LIM,
      OFS_SYSTEM_CONFIG, OFS_IRQ_STATUS, OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ---------------- stack pointer and limit checks ----------------
  // a core command wins the pointer over an apb write in the same cycle;
  // the apb write to the pointer is then dropped, it is rare in practice
  always_comb begin
    logic [15:0] nsp;
    logic        dec_class;
    logic        inc_class;
    nsp       = sp_q;
    dec_class = 1'b0;
    inc_class = 1'b0;
    sp_d      = sp_q;
    ovl_d     = ovl_q;
    unl_d     = unl_q;
    size_d    = size_q;
    mem_d     = '0;
    ovf_d     = 1'b0;
    unf_d     = 1'b0;
    case (cmd.op)
      OP_PUSH, OP_CALL: begin
        nsp       = fit_window(sp_q - WORD_STEP); // RULE1
        dec_class = 1'b1;
        mem_d     = '{valid: 1'b1, write: 1'b1, addr: phys_addr(nsp, size_q)};
      end
      OP_POP, OP_RET: begin
        nsp       = fit_window(sp_q + WORD_STEP); // RULE1
        inc_class = 1'b1;
        mem_d     = '{valid: 1'b1, write: 1'b0, addr: phys_addr(sp_q, size_q)};
      end
      OP_SUB: begin
        nsp       = fit_window(sp_q - cmd.operand);
        dec_class = 1'b1;
      end
      OP_ADD: begin
        nsp       = fit_window(sp_q + cmd.operand);
        inc_class = 1'b1;
      end
      OP_MOV: begin
        nsp = fit_window(cmd.operand); // RULE5
      end
      default: begin
        nsp = sp_q;
      end
    endcase
    if (cmd.op != OP_NONE) begin
      sp_d = nsp;
    end else if (wr_en && paddr == OFS_STACK_POINTER) begin
      sp_d = fit_window(wdata16); // RULE5
    end
    // compare the updated pointer, one pulse per command
    ovf_d = dec_class && (nsp < ovl_q); // RULE3 RULE19
    unf_d = inc_class && (nsp > unl_q); // RULE4 RULE19
    if (wr_en && paddr == OFS_OVERFLOW_LIM) begin
      ovl_d = fit_window(wdata16); // RULE6
    end
    if (wr_en && paddr == OFS_UNDERFLOW_LIM) begin
      unl_d = fit_window(wdata16); // RULE6
    end
    if (wr_en && paddr == OFS_SYSTEM_CONFIG) begin
      size_d = pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q   <= SP_RESET; // RULE11
      ovl_q  <= OVL_RESET;
      unl_q  <= UNL_RESET;
      size_q <= SIZE_RESET;
      mem_q  <= '0;
      ovf_q  <= 1'b0;
      unf_q  <= 1'b0;
    end else begin
      sp_q   <= sp_d;
      ovl_q  <= ovl_d;
      unl_q  <= unl_d;
      size_q <= size_d;
      mem_q  <= mem_d;
      ovf_q  <= ovf_d;
      unf_q  <= unf_d;
    end
  end

  // ---------------- user stack addressing ----------------
  // no limit comparison here at all, the pointer lives in a general register
  always_comb begin
    logic [15:0] step;
    step   = ustk_req.is_byte ? BYTE_STEP : WORD_STEP;
    ustk_d = '0;
    case (ustk_req.mode)
      USTK_PREDEC: begin
        ustk_d.valid = 1'b1;
        if (ustk_req.is_mov) begin
          ustk_d.new_ptr = ustk_req.ptr - step; // RULE17 RULE16
          ustk_d.addr    = ustk_req.ptr - step;
        end else begin
          ustk_d.refused = 1'b1; // RULE17
          ustk_d.new_ptr = ustk_req.ptr;
          ustk_d.addr    = ustk_req.ptr;
        end
      end
      USTK_POSTINC: begin
        ustk_d.valid = 1'b1;
        ustk_d.addr  = ustk_req.ptr;
        // index form of non-move instructions limited to the low registers
        if (ustk_req.is_mov || ustk_req.reg_index <= POSTINC_MAX_REG) begin
          ustk_d.new_ptr = ustk_req.ptr + step; // RULE18 RULE16
        end else begin
          ustk_d.refused = 1'b1; // RULE18
          ustk_d.new_ptr = ustk_req.ptr;
        end
      end
      default: begin
        ustk_d = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ustk_q <= '0;
    end else begin
      ustk_q <= ustk_d;
    end
  end

  // ---------------- interrupt status ----------------
  // events: traps, linear access outside ram, reserved size use, refused mode
  always_comb begin
    events                = '0;
    events[STAT_OVF]      = ovf_d;
    events[STAT_UNF]      = unf_d;
    events[STAT_LINEAR]   = mem_d.valid && size_q == SIZE_LINEAR &&
                            (mem_d.addr < LINEAR_LOW || mem_d.addr > LINEAR_HIGH); // RULE10
    events[STAT_RSVSIZE]  = mem_d.valid && size_q != SIZE_LINEAR &&
                            size_q > SIZE_32;
    events[STAT_USTK]     = ustk_d.refused;
    status_d = status_q;
    mask_d   = mask_q;
    if (wr_en && paddr == OFS_IRQ_STATUS) begin
      status_d = status_q & ~pwdata[STAT_W-1:0];
    end
    // a set in the same cycle as its clear survives
    status_d = status_d | events;
    if (wr_en && paddr == OFS_IRQ_MASK) begin
      mask_d = pwdata[STAT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      mask_q   <= MASK_RESET;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  // ---------------- apb read path ----------------
  // read data captured in setup so it comes from a flip-flop in access
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_ph) begin
      pslverr_d = ~mapped;
      case (paddr)
        OFS_STACK_POINTER: prdata_d = {16'h0000, sp_q};
        OFS_OVERFLOW_LIM:  prdata_d = {16'h0000, ovl_q};
        OFS_UNDERFLOW_LIM: prdata_d = {16'h0000, unl_q};
        OFS_SYSTEM_CONFIG: prdata_d = {29'h0000_0000, size_q};
        OFS_IRQ_STATUS:    prdata_d = {27'h0000_0000, status_q};
        OFS_IRQ_MASK:      prdata_d = {27'h0000_0000, mask_q};
        default:           prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // outputs
  assign prdata         = prdata_q;
  assign pready         = penable;          // zero wait states
  assign pslverr        = pslverr_q & psel & penable;
  assign stack_pointer  = sp_q;
  assign mem_req        = mem_q;
  assign overflow_trap  = ovf_q;
  assign underflow_trap = unf_q;
  assign ustk_rsp       = ustk_q;
  assign irq            = |(status_q & mask_q);

endmodule

`default_nettype wire

// >>> tb_system_stack_limit_unit.sv
// testbench: apb and core command tasks, an inline user stack loop, with expectations.
// assumes a 100 MHz pclk and a zero-wait apb slave.
`timescale 1ns/100ps
`default_nettype none
module tb_system_stack_limit_unit;
  import stack_unit_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, irq, err, ovf, unf;
  logic        overflow_trap, underflow_trap, ram_wr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] stack_pointer, sp, e, m, ram_addr;
  stack_cmd_t  cmd;
  mem_req_t    mem_req;
  ustk_req_t   ustk_req;
  ustk_rsp_t   ustk_rsp, rsp;
  int          mismatches = 0, checks_done = 0, cycles = 0;
  logic [15:0] rst_tab [7] = '{16'hfc00, 16'hfa00, 16'hfc00, 0, 0, 0, 0};
  logic [2:0]  codes [6] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b111, 3'b111};
  stack_op_t   tops [9] = '{OP_MOV, OP_PUSH, OP_PUSH, OP_SUB, OP_CALL, OP_MOV, OP_POP,
                            OP_RET, OP_ADD};
  logic [15:0] tv [9] = '{16'hf800, 0, 0, 2, 0, 16'hfbfe, 0, 0, 2};
  logic [15:0] tsp [9] = '{16'hf800, 16'hf7fe, 16'hf7fc, 16'hf7fa, 16'hf7f8, 16'hfbfe,
                           16'hfc00, 16'hfc02, 16'hfc04};
  logic [1:0]  ttr [9] = '{0, 0, 2, 2, 2, 0, 0, 1, 1};
  logic [16:0] tram [9] = '{17'h1f600, 17'h1fbfe, 17'h1fbfc, 17'h1fbfc, 17'h1fbf8,
                            17'h1fbf8, 17'h0fbfe, 17'h0fa00, 17'h0fa00};
  ustk_req_t   ureq [6] = '{'{USTK_PREDEC, 1, 0, 1, 16'h1000}, '{USTK_PREDEC, 1, 1, 2, 16'h1000},
    '{USTK_PREDEC, 0, 0, 5, 16'h1000}, '{USTK_POSTINC, 0, 1, 3, 16'h1000},
    '{USTK_POSTINC, 0, 0, 4, 16'h1000}, '{USTK_POSTINC, 1, 0, 9, 16'h1000}};
  logic [33:0] uexp [6] = '{{2'b10, 32'h0ffe_0ffe}, {2'b10, 32'h0fff_0fff},
    {2'b11, 32'h1000_1000}, {2'b10, 32'h1001_1000}, {2'b11, 32'h1000_1000},
    {2'b10, 32'h1002_1000}};

  system_stack_limit_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cmd, .stack_pointer, .mem_req, .overflow_trap,
    .underflow_trap, .ustk_req, .ustk_rsp, .irq);
  stack_ram_model ram (.pclk, .mem_req, .last_addr(ram_addr), .last_write(ram_wr));

  always #5 pclk = ~pclk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [39:0] exp, input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", w, exp, got);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // one core command, then a quiet cycle so the ram model catches up
  task automatic op(input stack_op_t o, input logic [15:0] v);
    @(posedge pclk);
    cmd <= '{o, v};
    @(posedge pclk);
    cmd <= '{OP_NONE, 16'h0000};
    #1;
    ovf = overflow_trap;
    unf = underflow_trap;
    sp = stack_pointer;
    @(posedge pclk);
    #1;
    chk("trap pulse", 40'h0, 40'({overflow_trap, underflow_trap}));
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cmd = '0;
    ustk_req = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, the last offset is unmapped
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk("reset value", 40'(rst_tab[i]), 40'(q));
      chk("slave error", 40'(i == 6), 40'(err));
    end
    apb(1'b1, OFS_STACK_POINTER, 32'h0000_1235);
    apb(1'b0, OFS_STACK_POINTER, 32'h0000_0000);
    chk("pointer load", 40'h0f234, 40'(q));
    // each non-reserved size code: push from f800, linear from f602 stays in ram
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_SYSTEM_CONFIG, 32'(codes[i]));
      op(OP_MOV, (i == 5) ? 16'hf602 : 16'hf800);
      e = sp;
      op(OP_PUSH, 16'h0000);
      m = (16'h0200 >> codes[i]) - 16'h0001;
      e = (codes[i] == 3'b111) ? e - 16'h0002 : (16'hfbfe & ~m) | ((e - 16'h0002) & m);
      chk("push address", 40'({1'b1, e}), 40'({ram_wr, ram_addr}));
      chk("push trap", 40'h2, 40'({ovf, unf}));
    end
    // trap status raises irq only when unmasked
    apb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    chk("status", 40'h1, 40'(q));
    chk("irq masked", 40'h0, 40'(irq));
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_001f);
    chk("irq raised", 40'h1, 40'(irq));
    apb(1'b1, OFS_IRQ_STATUS, 32'h0000_001f);
    chk("irq cleared", 40'h0, 40'(irq));
    // limit boundaries for every kind of pointer change
    apb(1'b1, OFS_OVERFLOW_LIM, 32'h0000_f7fe);
    apb(1'b1, OFS_SYSTEM_CONFIG, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      op(tops[i], tv[i]);
      chk("pointer", 40'(tsp[i]), 40'(sp));
      chk("traps", 40'(ttr[i]), 40'({ovf, unf}));
      chk("ram access", 40'(tram[i]), 40'({ram_wr, ram_addr}));
    end
    // circular use: overflow limit six words above the 256 word area floor
    apb(1'b1, OFS_OVERFLOW_LIM, 32'h0000_fa0c);
    op(OP_MOV, 16'hfa0e);
    op(OP_PUSH, 16'h0000);
    chk("reserve edge", 40'h1fa0c, 40'({ovf, unf, ram_wr, ram_addr}));
    op(OP_PUSH, 16'h0000);
    chk("reserve entry", 40'h5fa0a, 40'({ovf, unf, ram_wr, ram_addr}));
    // user stack modes
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      ustk_req <= ureq[i];
      @(posedge pclk);
      ustk_req <= '0;
      #1;
      rsp = ustk_rsp;
      chk("user stack", 40'(uexp[i]), 40'(rsp));
    end
    apb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    chk("status", 40'h13, 40'(q));
    chk("irq level", 40'h1, 40'(irq));
    final_report();
  end
endmodule
`default_nettype wire
